// ===== rls_far_side.sv
// System-side model: dedicated inputs, bus line levels, forced registered pins, OE levels
`timescale 1ns/1ps
module rls_far_side
   import rls_pkg::*;
(
   input wire logic CLK,
   input wire logic [N_BUS-1:0] B_OUT,
   input wire logic [N_BUS-1:0] B_OE,
   input wire logic [N_FF-1:0] F_OUT,
   input wire logic [N_FF-1:0] F_OE,
   input wire logic [N_IN-1:0] i_val,
   input wire logic [N_FF-1:0] f_drv,
   input wire logic [N_FF-1:0] f_val,
   input wire logic oe_req,
   input wire logic hv_req,
   output logic [N_IN-1:0] I_PIN,
   output logic [N_BUS-1:0] B_IN,
   output logic [N_FF-1:0] F_IN,
   output logic OE_PIN,
   output logic OE_HV_PIN
);
   logic [N_BUS-1:0] b_last = '0;
   logic [N_FF-1:0] f_last = '0;
   // Released lines flip every cycle so a stale level never passes for data
   always @(posedge CLK) begin
      b_last <= ~B_IN;
      f_last <= ~F_IN;
   end
   assign I_PIN = i_val;
   assign B_IN = (B_OE & B_OUT) | (~B_OE & b_last);
   // Pins are forced only while the device has its outputs off
   assign F_IN = (F_OE & F_OUT) | (~F_OE & f_drv & f_val) | (~F_OE & ~f_drv & f_last);
   assign OE_PIN = oe_req | hv_req;
   assign OE_HV_PIN = hv_req;
endmodule

// ===== rls_fuse_store.sv
// Fuse map storage: programmable links as words, parallel view plus registered read port
`timescale 1ns/1ps
module rls_fuse_store
   import rls_pkg::*;
(
   input wire logic CLK,
   input wire logic NRST,
   input wire logic wr_en,
   input wire logic rd_en,
   input wire logic [IDX_W-1:0] idx,
   input wire logic [31:0] wdata,
   input wire logic [3:0] sel,
   output logic [31:0] rdata,
   output logic [31:0] words [MAP_WORDS]
);
   always_ff @(posedge CLK or negedge NRST) begin
      if (!NRST) begin
         for (int i = 0; i < MAP_WORDS; i++) begin
            words[i] <= rls_reset_word(i);
         end
      end else if (wr_en && rls_in_map(idx)) begin
         for (int b = 0; b < 4; b++) begin
            if (sel[b]) begin
               words[idx][8*b +: 8] <= wdata[8*b +: 8];
            end
         end
      end
   end

   always_ff @(posedge CLK or negedge NRST) begin
      if (!NRST) begin
         rdata <= 32'h00000000;
      end else if (rd_en && rls_in_map(idx)) begin
         rdata <= words[idx];
      end
   end
endmodule

// ===== rls_pkg.sv
// Constants, fuse map layout and helper functions for the registered logic sequencer
package rls_pkg;
   localparam int N_IN = 4;
   localparam int N_BUS = 8;
   localparam int N_FF = 4;
   localparam int N_LIT = 17;
   localparam int N_LOGIC = 32;
   localparam int N_CTRL = 13;
   localparam int N_TERMS = 45;
   localparam int N_SUMS = 21;
   // Literal positions inside one array input vector
   localparam int LIT_I = 0;
   localparam int LIT_B = 4;
   localparam int LIT_Q = 12;
   localparam int LIT_C = 16;
   localparam logic [16:0] LIT_NO_CMPL = 17'h0ffff;
   // Control term positions
   localparam int T_LOAD = 32;
   localparam int T_DIR = 36;
   localparam int T_FOLD = 44;
   // Sum gate positions
   localparam int S_BUS = 0;
   localparam int S_J = 8;
   localparam int S_K = 12;
   localparam int S_PRE = 16;
   localparam int S_RST = 18;
   localparam int S_OEGATE = 20;
   // Fuse map word indices; byte address is four times the index
   localparam int IDX_W = 7;
   localparam int IDX_AND_T = 0;
   localparam int IDX_AND_C = 45;
   localparam int IDX_OR = 90;
   localparam int IDX_CMPL = 111;
   localparam int IDX_POL = 112;
   localparam int MAP_WORDS = 113;
   localparam logic [6:0] IDX_STATUS = 7'h71;
   localparam int ADR_W = 9;
   // Status word fields
   localparam int ST_Q = 0;
   localparam int ST_B = 4;
   localparam int ST_I = 12;
   localparam int ST_OE = 16;
   localparam int ST_HV = 17;
   localparam int ST_FOLD = 18;
   // Synchronised pin vector layout
   localparam int PIN_W = 18;
   localparam int P_I = 0;
   localparam int P_B = 4;
   localparam int P_F = 12;
   localparam int P_OE = 16;
   localparam int P_HV = 17;
   // Virgin state: every AND link pair intact, so every term is inactive
   localparam logic [31:0] RST_AND = 32'h0001ffff;
   localparam logic [31:0] RST_OTHER = 32'h00000000;

   function automatic logic [31:0] rls_reset_word(input int idx);
      rls_reset_word = (idx < IDX_OR) ? RST_AND : RST_OTHER;
   endfunction

   // A term is high when every selected true literal is high and every selected
   // complement literal is low; an intact true/complement pair kills the term
   function automatic logic rls_term(input logic [16:0] tsel, input logic [16:0] csel,
                                     input logic [16:0] v);
      rls_term = (&(~tsel | v)) & (&(~csel | ~v));
   endfunction

   function automatic logic rls_in_map(input logic [6:0] idx);
      rls_in_map = (int'(idx) < MAP_WORDS);
   endfunction
endpackage

// ===== rls_sequencer.sv
// Registered logic sequencer: AND/OR array, four J-K flip-flops, bus lines, Wishbone slave
//
// Local design decisions: register access over Wishbone and the placing of the registers.
`timescale 1ns/1ps
module rls_sequencer
   import rls_pkg::*;
(
   input wire logic CLK,
   input wire logic NRST,
   input wire logic CYC_I,
   input wire logic STB_I,
   input wire logic WE_I,
   input wire logic [ADR_W-1:0] ADR_I,
   input wire logic [3:0] SEL_I,
   input wire logic [31:0] DAT_I,
   output logic [31:0] DAT_O,
   output logic ACK_O,
   input wire logic [N_IN-1:0] I_PIN,
   input wire logic [N_BUS-1:0] B_IN,
   output logic [N_BUS-1:0] B_OUT,
   output logic [N_BUS-1:0] B_OE,
   input wire logic [N_FF-1:0] F_IN,
   output logic [N_FF-1:0] F_OUT,
   output logic [N_FF-1:0] F_OE,
   input wire logic OE_PIN,
   input wire logic OE_HV_PIN
);
   logic [PIN_W-1:0] pin_s1;
   logic [PIN_W-1:0] pin_s2;
   logic [PIN_W-1:0] pin_s3;
   logic [PIN_W-1:0] pin_q;
   logic [31:0] words [MAP_WORDS];
   logic [31:0] mem_rdata;
   logic [31:0] stat_q;
   logic [31:0] status;
   logic hit_q;
   logic req;
   logic mem_hit;
   logic [IDX_W-1:0] wb_idx;
   logic [N_LIT-1:0] lits;
   logic [N_LOGIC-1:0] pre_term;
   logic cmpl;
   logic [N_TERMS-1:0] terms;
   logic [N_SUMS-1:0] sums;
   logic [N_FF-1:0] q;
   logic [N_FF-1:0] j;
   logic [N_FF-1:0] k;
   logic [N_FF-1:0] ld;
   logic [N_FF-1:0] pre_eff;
   logic [N_FF-1:0] rst_eff;
   logic [N_FF-1:0] normal;
   logic [N_BUS-1:0] bus_val;
   logic fold;
   logic oe;
   logic hv;

   // Pins are asynchronous; a bit is accepted once the second and third stages agree
   always_ff @(posedge CLK or negedge NRST) begin
      if (!NRST) begin
         pin_s1 <= '0;
         pin_s2 <= '0;
         pin_s3 <= '0;
      end else begin
         pin_s1 <= {OE_HV_PIN, OE_PIN, F_IN, B_IN, I_PIN};
         pin_s2 <= pin_s1;
         pin_s3 <= pin_s2;
      end
   end

   always_ff @(posedge CLK or negedge NRST) begin
      if (!NRST) begin
         pin_q <= '0;
      end else begin
         for (int i = 0; i < PIN_W; i++) begin
            if (pin_s2[i] == pin_s3[i]) begin
               pin_q[i] <= pin_s3[i];
            end
         end
      end
   end

   assign oe = pin_q[P_OE];
   assign hv = pin_q[P_HV];

   // Wishbone classic slave: ack one cycle after the request, write lands on the ack edge
   assign req = CYC_I & STB_I;
   assign wb_idx = ADR_I[ADR_W-1:2];
   assign mem_hit = rls_in_map(wb_idx);

   always_ff @(posedge CLK or negedge NRST) begin
      if (!NRST) begin
         ACK_O <= 1'b0;
      end else begin
         ACK_O <= req & ~ACK_O;
      end
   end

   rls_fuse_store u_store (
      .CLK(CLK),
      .NRST(NRST),
      .wr_en(req & WE_I & ACK_O & mem_hit),
      .rd_en(req & ~ACK_O & mem_hit),
      .idx(wb_idx),
      .wdata(DAT_I),
      .sel(SEL_I),
      .rdata(mem_rdata),
      .words(words)
   );

   always_comb begin
      status = 32'h00000000;
      status[ST_Q +: N_FF] = q;
      status[ST_B +: N_BUS] = pin_q[P_B +: N_BUS];
      status[ST_I +: N_IN] = pin_q[P_I +: N_IN];
      status[ST_OE] = oe;
      status[ST_HV] = hv;
      status[ST_FOLD] = fold;
   end

   // Unmapped addresses still get an ack; all but the status word read as zero
   always_ff @(posedge CLK or negedge NRST) begin
      if (!NRST) begin
         hit_q <= 1'b0;
         stat_q <= 32'h00000000;
      end else if (req && !ACK_O) begin
         hit_q <= mem_hit;
         if (wb_idx == IDX_STATUS) begin
            stat_q <= status;
         end else begin
            stat_q <= 32'h00000000;
         end
      end
   end

   assign DAT_O = hit_q ? mem_rdata : stat_q;

   // The complement term is evaluated from a first pass that ignores its own literal,
   // which breaks the combinational loop a true feedback NOR would form
   always_comb begin
      lits = {1'b0, q, pin_q[P_B +: N_BUS], pin_q[P_I +: N_IN]};
      for (int t = 0; t < N_LOGIC; t++) begin
         pre_term[t] = rls_term(words[IDX_AND_T + t][N_LIT-1:0] & LIT_NO_CMPL,
                                words[IDX_AND_C + t][N_LIT-1:0] & LIT_NO_CMPL, lits);
      end
      cmpl = ~|(pre_term & words[IDX_CMPL]);
      lits[LIT_C] = cmpl;
      for (int t = 0; t < N_TERMS; t++) begin
         terms[t] = rls_term(words[IDX_AND_T + t][N_LIT-1:0],
                             words[IDX_AND_C + t][N_LIT-1:0], lits);
      end
      for (int s = 0; s < N_SUMS; s++) begin
         sums[s] = |(terms[N_LOGIC-1:0] & words[IDX_OR + s]);
      end
   end

   // Flip-flop steering; the fold-back term turns J-K into D by forcing K to not J
   always_comb begin
      fold = terms[T_FOLD];
      ld = terms[T_LOAD +: N_FF];
      for (int n = 0; n < N_FF; n++) begin
         j[n] = sums[S_J + n];
         k[n] = fold ? ~sums[S_J + n] : sums[S_K + n];
         pre_eff[n] = sums[S_PRE + n / 2] & ~hv;
         rst_eff[n] = sums[S_RST + n / 2] & ~hv;
         normal[n] = ~pre_eff[n] & ~rst_eff[n] & ~ld[n] & ~hv;
      end
   end

   // Preset and reset are array outputs, so they act without the clock
   for (genvar n = 0; n < N_FF; n++) begin : g_ff
      // One variable per flop keeps each bit under a single driving process
      logic state;
      always_ff @(posedge CLK or negedge NRST or posedge pre_eff[n] or posedge rst_eff[n]) begin
         if (!NRST) begin
            state <= 1'b0;
         end else if (pre_eff[n]) begin
            state <= 1'b1;
         end else if (rst_eff[n]) begin
            state <= 1'b0;
         end else if (ld[n] || hv) begin
            state <= ~pin_q[P_F + n];
         end else begin
            case ({j[n], k[n]})
               2'b01: state <= 1'b0;
               2'b10: state <= 1'b1;
               2'b11: state <= ~state;
               default: state <= state;
            endcase
         end
      end
      assign q[n] = state;
   end

   assign F_OUT = ~q;
   // Sum 20 acts as a programmable output disable next to the pin
   assign F_OE = {N_FF{~oe & ~hv & ~sums[S_OEGATE]}};

   assign bus_val = sums[S_BUS +: N_BUS] ^ words[IDX_POL][N_BUS-1:0];

   // Bus lines are registered, trading one cycle of latency for glitch-free pins
   always_ff @(posedge CLK or negedge NRST) begin
      if (!NRST) begin
         B_OUT <= '0;
         B_OE <= '0;
      end else begin
         B_OUT <= bus_val;
         B_OE <= terms[T_DIR +: N_BUS] & {N_BUS{~hv}};
      end
   end

   default clocking cb @(posedge CLK);
   endclocking
   default disable iff (!NRST);

   property p_f_hiz;
      oe |-> (F_OE == '0);
   endproperty
   a_f_hiz: assert property (p_f_hiz) else $error("registered pins driven while disabled");

   property p_bus_pol;
      1'b1 |=> (B_OUT == $past(bus_val));
   endproperty
   a_bus_pol: assert property (p_bus_pol) else $error("bus line polarity mismatch");

   property p_diag_bus_off;
      hv |=> (B_OE == '0);
   endproperty
   a_diag_bus_off: assert property (p_diag_bus_off) else $error("bus driven in diagnostic");

   property p_ack_once;
      req && !ACK_O |=> ACK_O ##1 !ACK_O;
   endproperty
   a_ack_once: assert property (p_ack_once) else $error("ack not a single cycle pulse");

   // Ack never follows a cycle in which no request is present
   property p_ack_idle;
      !req |=> !ACK_O;
   endproperty
   a_ack_idle: assert property (p_ack_idle) else $error("ack without a request");

   property p_f_drive;
      !oe && !hv && !sums[S_OEGATE] |-> (F_OE == {N_FF{1'b1}});
   endproperty
   a_f_drive: assert property (p_f_drive) else $error("registered pins not driven");

   property p_hv_fz;
      hv |-> (F_OE == '0);
   endproperty
   a_hv_fz: assert property (p_hv_fz) else $error("registered pins driven in diagnostic");

   // With no term selected the NOR has no inputs and must stay high
   property p_cmpl_empty;
      (words[IDX_CMPL] == 32'h00000000) |-> cmpl;
   endproperty
   a_cmpl_empty: assert property (p_cmpl_empty) else $error("empty complement term low");

   for (genvar n = 0; n < N_FF; n++) begin : g_chk
      sequence s_quiet;
         !pre_eff[n] && !rst_eff[n];
      endsequence
      sequence s_preload;
         (ld[n] || hv) && !pre_eff[n] && !rst_eff[n];
      endsequence

      property p_hold;
         normal[n] && !j[n] && !k[n] ##1 s_quiet |-> q[n] == $past(q[n]);
      endproperty
      a_hold: assert property (p_hold) else $error("flip-flop did not hold");

      property p_toggle;
         normal[n] && j[n] && k[n] ##1 s_quiet |-> q[n] != $past(q[n]);
      endproperty
      a_toggle: assert property (p_toggle) else $error("flip-flop did not toggle");

      property p_dmode;
         normal[n] && fold ##1 s_quiet |-> q[n] == $past(j[n]);
      endproperty
      a_dmode: assert property (p_dmode) else $error("fold-back D mode wrong");

      property p_preload;
         s_preload ##1 s_quiet |-> q[n] == !$past(pin_q[P_F + n]);
      endproperty
      a_preload: assert property (p_preload) else $error("preload not captured");

      property p_preset;
         pre_eff[n] ##1 pre_eff[n] |-> q[n];
      endproperty
      a_preset: assert property (p_preset) else $error("preset did not set");

      property p_reset;
         rst_eff[n] && !pre_eff[n] ##1 rst_eff[n] && !pre_eff[n] |-> !q[n];
      endproperty
      a_reset: assert property (p_reset) else $error("reset did not clear");

      property p_set;
         normal[n] && j[n] && !k[n] ##1 s_quiet |-> q[n];
      endproperty
      a_set: assert property (p_set) else $error("flip-flop did not set");

      property p_clear;
         normal[n] && !j[n] && k[n] ##1 s_quiet |-> !q[n];
      endproperty
      a_clear: assert property (p_clear) else $error("flip-flop did not clear");

      property p_diag_quiet;
         hv |-> !pre_eff[n] && !rst_eff[n];
      endproperty
      a_diag_quiet: assert property (p_diag_quiet) else $error("preset active in diagnostic");
   end
endmodule

// ===== tb.sv
// Self-checking bench for the registered logic sequencer
`timescale 1ns/1ps
module tb;
   import rls_pkg::*;
   logic CLK = 0;
   logic NRST = 0;
   logic CYC_I = 0;
   logic STB_I = 0;
   logic WE_I = 0;
   logic [ADR_W-1:0] ADR_I = '0;
   logic [3:0] SEL_I = '0;
   logic [31:0] DAT_I = '0;
   logic [31:0] DAT_O, q;
   logic ACK_O, OE_PIN, OE_HV_PIN;
   logic [N_IN-1:0] I_PIN;
   logic [N_BUS-1:0] B_IN, B_OUT, B_OE;
   logic [N_FF-1:0] F_IN, F_OUT, F_OE;
   logic [N_IN-1:0] i_val = '0;
   logic [N_FF-1:0] f_drv = '0;
   logic [N_FF-1:0] f_val = '0;
   logic oe_req = 0;
   logic hv_req = 0;
   logic [31:0] seed = 32'hb5985348;
   logic [31:0] mem [MAP_WORDS];
   int idx_tab [6] = '{0, 44, 89, 90, 112, 120};
   int jk [4] = '{2, 0, 1, 0};
   int fail_count = 0;
   int compares = 0;
   initial begin
      forever #50 CLK = ~CLK;
   end
   rls_sequencer rls_sequencer_inst (.CLK, .NRST, .CYC_I, .STB_I, .WE_I, .ADR_I, .SEL_I,
      .DAT_I, .DAT_O, .ACK_O, .I_PIN, .B_IN, .B_OUT, .B_OE, .F_IN, .F_OUT, .F_OE, .OE_PIN,
      .OE_HV_PIN);
   rls_far_side rls_far_side_inst (.CLK, .B_OUT, .B_OE, .F_OUT, .F_OE, .i_val, .f_drv,
      .f_val, .oe_req, .hv_req, .I_PIN, .B_IN, .F_IN, .OE_PIN, .OE_HV_PIN);
   function automatic logic [31:0] xs(input logic [31:0] s);
      logic [31:0] x;
      x = s ^ (s << 13);
      x = x ^ (x >> 17);
      xs = x ^ (x << 5);
   endfunction
   task automatic results();
      $display("checks %0d mismatches %0d", compares, fail_count);
      if (fail_count == 0 && compares > 0) begin
         $display("TEST PASSED");
      end else begin
         $display("TEST FAILED");
      end
      $finish;
   endtask
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      compares++;
      if (got !== exp) begin
         fail_count++;
         $display("unexpected at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   // Ack latency is never assumed; only the bounded wait ends it
   task automatic wb(input logic we, input int idx, input logic [31:0] d, input logic [3:0] s);
      int n;
      n = 0;
      @(posedge CLK);
      CYC_I <= 1;
      STB_I <= 1;
      WE_I <= we;
      ADR_I <= ADR_W'(idx * 4);
      SEL_I <= s;
      DAT_I <= d;
      // Ack and data are read at the rising edge, before that edge's updates land
      @(posedge CLK);
      while (ACK_O !== 1'b1 && n < 20) begin
         @(posedge CLK);
         n++;
      end
      if (n >= 20) begin
         fail_count++;
         results();
      end
      q = DAT_O;
      CYC_I <= 0;
      STB_I <= 0;
   endtask
   task automatic wr(input int idx, input logic [31:0] d, input logic [3:0] s);
      wb(1, idx, d, s);
      for (int b = 0; b < 4; b++) begin
         if (s[b] && idx < MAP_WORDS) begin
            mem[idx][8*b +: 8] = d[8*b +: 8];
         end
      end
   endtask
   task automatic rd(input int idx);
      wb(0, idx, 32'h0, 4'hf);
      chk(q, (idx < MAP_WORDS) ? mem[idx] : 32'h0);
   endtask
   task automatic st(input logic [3:0] e);
      wb(0, int'(IDX_STATUS), 32'h0, 4'hf);
      chk({28'h0, q[3:0]}, {28'h0, e});
      chk({28'h0, F_OUT}, {28'h0, ~e});
      chk({28'h0, q[ST_I +: N_IN]}, {28'h0, i_val});
   endtask
   // An intact link pair kills a term; clearing both words makes it constantly true
   task automatic on(input int t);
      wr(t, 0, 4'hf);
      wr(IDX_AND_C + t, 0, 4'hf);
   endtask
   initial begin
      logic q0;
      q0 = 0;
      for (int i = 0; i < MAP_WORDS; i++) begin
         mem[i] = (i < IDX_OR) ? 32'h0001ffff : 32'h0;
      end
      repeat (6) @(posedge CLK);
      chk({16'h0, B_OE, F_OUT, F_OE}, 32'h000000ff);
      NRST <= 1;
      foreach (idx_tab[k]) rd(idx_tab[k]);
      for (int k = 0; k < 6; k++) begin
         seed = xs(seed);
         i_val <= seed[7:4];
         wr(IDX_OR + int'(seed[31:8] % 23), seed, seed[3:0]);
         rd(IDX_OR + int'(seed[31:8] % 23));
      end
      for (int k = IDX_OR; k < MAP_WORDS; k++) wr(k, 0, 4'hf);
      wr(int'(IDX_STATUS), 32'hffffffff, 4'hf);
      st(4'h0);
      on(0);
      foreach (jk[k]) begin
         wr(IDX_OR + S_J, 32'(jk[k] >> 1), 4'hf);
         wr(IDX_OR + S_K, 32'(jk[k] & 1), 4'hf);
         q0 = (jk[k] == 2) ? 1'b1 : (jk[k] == 1) ? 1'b0 : q0;
         st({3'b0, q0});
      end
      wr(IDX_OR + S_J, 1, 4'hf);
      wr(IDX_OR + S_K, 1, 4'hf);
      @(negedge CLK);
      q = {28'h0, F_OUT};
      @(negedge CLK);
      chk({28'h0, F_OUT}, q ^ 32'h1);
      wr(IDX_OR + S_K, 0, 4'hf);
      wr(IDX_OR + S_J, 0, 4'hf);
      on(T_FOLD);
      st(4'h0);
      wr(IDX_OR + S_J, 1, 4'hf);
      st(4'h1);
      wr(T_FOLD, 32'h0001ffff, 4'hf);
      wr(IDX_OR + S_J, 0, 4'hf);
      wr(IDX_OR + S_RST, 1, 4'hf);
      st(4'h0);
      wr(IDX_OR + S_PRE, 1, 4'hf);
      st(4'h3);
      wr(IDX_OR + S_RST, 0, 4'hf);
      wr(IDX_OR + S_PRE, 0, 4'hf);
      st(4'h3);
      on(T_DIR);
      wr(IDX_OR + S_BUS, 1, 4'hf);
      repeat (2) @(negedge CLK);
      chk({B_OE, B_OUT[0]}, 9'h3);
      wr(IDX_POL, 1, 4'hf);
      repeat (2) @(negedge CLK);
      chk({B_OE, B_OUT[0]}, 9'h2);
      @(posedge CLK);
      hv_req <= 1;
      repeat (6) @(negedge CLK);
      chk({B_OE, F_OE}, 0);
      @(posedge CLK);
      hv_req <= 0;
      for (int v = 0; v < 2; v++) begin
         @(posedge CLK);
         oe_req <= 1;
         f_drv <= 4'h1;
         f_val <= 4'(v);
         on(T_LOAD);
         repeat (6) @(negedge CLK);
         chk({28'h0, F_OE}, 0);
         wr(T_LOAD, 32'h0001ffff, 4'hf);
         @(posedge CLK);
         oe_req <= 0;
         f_drv <= 0;
         st(4'h2 | 4'(1 - v));
      end
      repeat (6) @(negedge CLK);
      chk({28'h0, F_OE}, 32'hf);
      wr(1, 32'h00010000, 4'hf);
      wr(IDX_AND_C + 1, 0, 4'hf);
      wr(IDX_OR + S_OEGATE, 2, 4'hf);
      @(negedge CLK);
      chk({28'h0, F_OE}, 0);
      wr(IDX_CMPL, 1, 4'hf);
      @(negedge CLK);
      chk({28'h0, F_OE}, 32'hf);
      results();
   end
endmodule
